// [verilog/acc_sample_start_ctrl.sv]
// conversion sequencer, output coding, serial port and axi4-lite registers
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
// Notes on behaviour
// - start rise with trim high: self-calibrate
// - start rise with trim low: one conversion
// - start held high, trim low: continuous conversions
// - range select high bipolar, low unipolar
// - channel select 0 pair one, 1 pair two
// - channel latched only on start rising edge
// - undriven channel select reads as zero; this block has no pull-down, so an undriven pin reads unknown
// - bipolar code is offset binary
// - shift clock alone paces serial output
// - conversion takes 1624 master clock cycles
// - load word only if port empty or deselected
// - word ready goes low on port load
// - first rise arms, later falls shift bits
module acc_sample_start_ctrl
  import acc_pkg::*;
(
  input  wire logic              SYS_CLK,
  input  wire logic              RST_B,
  input  wire logic              SAMPLE_START,
  input  wire logic              TRIM_REQUEST,
  input  wire logic              SIGNED_RANGE_SELECT,
  input  wire logic              CHANNEL_SELECT,
  input  wire logic              PORT_SELECT_N,
  input  wire logic              SHIFT_CLK,
  input  wire logic [19:0]       FILTER_WORD,
  output logic                   SERIAL_OUT,
  output logic                   SERIAL_OUT_EN,
  output logic                   WORD_READY_N,
  output logic                   CHANNEL_ACTIVE,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  output logic [1:0]             S_AXI_BRESP,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP
);

  acc_state_s q;          // registered state
  acc_state_s n;          // next state
  acc_pins_s  pins_raw;   // pins as they arrive
  acc_pins_s  pins;       // pins after two flops
  logic       start_rise; // one-cycle start edge
  logic       sclk_rise;  // shift clock rising
  logic       sclk_fall;  // shift clock falling
  logic [19:0] corr;      // offset-corrected filter word
  logic [19:0] code;      // formatted output code

  assign pins_raw = '{sclk: SHIFT_CLK, sel_n: PORT_SELECT_N, chan: CHANNEL_SELECT,
                      bip: SIGNED_RANGE_SELECT, trim: TRIM_REQUEST, start: SAMPLE_START};

  // every control pin is asynchronous to the master clock
  acc_sync2 #(
    .W ($bits(acc_pins_s))
  ) u_pin_sync (
    .clk   (SYS_CLK),
    .rst_b (RST_B),
    .d     (pins_raw),
    .q     (pins)
  );

  // edges come from the synchronised copies only
  assign start_rise = pins.start & ~q.start_prev;
  assign sclk_rise  = pins.sclk & ~q.sclk_prev;
  assign sclk_fall  = ~pins.sclk & q.sclk_prev;

  // output coding; offset removed before range formatting
  always_comb begin
    corr = FILTER_WORD - q.offset;
    if (pins.bip) begin
      code = {~corr[19], corr[18:0]};
    end else if (corr[19]) begin
      code = '0; // negative input clamps in unipolar range
    end else begin
      code = {corr[18:0], 1'b0}; // unipolar spans the positive half only
    end
  end

  // next state: sequencer, serial port, bus slave
  always_comb begin
    n            = q;
    n.start_prev = pins.start;
    n.sclk_prev  = pins.sclk;

    // serial port; the shift clock sets the pace, not the master clock
    if (pins.sel_n) begin
      n.armed = 1'b0; // deselect drops the arming, word is kept
    end else if (q.port_full && q.sdo_en) begin
      if (sclk_rise) begin
        n.armed = 1'b1;
      end else if (sclk_fall && q.armed) begin
        if (q.bit_cnt == LAST_BIT) begin
          n.port_full = 1'b0; // lsb gone, port empty
          n.rdy_n     = 1'b1;
          n.armed     = 1'b0;
        end else begin
          n.shreg   = {q.shreg[18:0], 1'b0};
          n.bit_cnt = q.bit_cnt + 5'h1;
        end
      end
    end

    // sequencer
    case (q.mode)
      ACC_IDLE: begin
        if (start_rise && q.run) begin
          if (pins.trim) begin
            n.mode = ACC_CAL;
            n.cnt  = CAL_LOAD;
          end else begin
            n.mode = ACC_SAMPLE_START;
            n.cnt  = SAMPLE_START_LOAD;
            n.chan = pins.chan;
          end
        end
      end
      ACC_CAL: begin
        if (q.cnt == '0) begin
          n.offset   = FILTER_WORD; // offset trim captured from the filter word
          n.cal_done = 1'b1;
          n.mode     = ACC_IDLE;
        end else begin
          n.cnt = q.cnt - 13'h1;
        end
      end
      ACC_SAMPLE_START: begin
        // a deselected full port gives up its word ahead of the update
        if (q.cnt == LEAD_CNT && pins.sel_n && q.port_full) begin
          n.rdy_n = 1'b1;
        end
        if (q.cnt == '0) begin
          n.result = code;
          if (!q.port_full || pins.sel_n) begin
            n.shreg     = code;
            n.bit_cnt   = '0;
            n.port_full = 1'b1;
            n.armed     = 1'b0;
            n.rdy_n     = 1'b0;
          end
          if (pins.start && !pins.trim && q.run) begin
            n.cnt = SAMPLE_START_LOAD;
          end else begin
            n.mode = ACC_IDLE;
          end
        end else begin
          n.cnt = q.cnt - 13'h1;
        end
      end
      default: begin
        n.mode = ACC_IDLE; // unused code recovers
      end
    endcase

    // pin drivers follow the next port state so they stay registered
    n.sdo_en = n.port_full & ~pins.sel_n;
    n.sdo    = n.shreg[19];

    // write channel: address and data may arrive in either order
    if (S_AXI_AWVALID && q.awready) begin
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && q.wready) begin
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    if (q.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_got && n.w_got && !q.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      if (n.awaddr == ADDR_CTRL) begin
        if (n.wstrb[0]) begin
          n.run = n.wdata[CTRL_RUN_BIT]; // stops new starts, current one ends
        end
      end else if (n.awaddr == ADDR_STATUS || n.awaddr == ADDR_RESULT ||
                   n.awaddr == ADDR_OFFSET) begin
        n.bresp = RESP_OKAY; // read-only, write ignored
      end else begin
        n.bresp = RESP_SLVERR; // unmapped
      end
    end

    // read channel: data one cycle after the address is taken
    if (q.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
    end
    if (S_AXI_ARVALID && q.arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = '0;
      if (S_AXI_ARADDR == ADDR_CTRL) begin
        n.rdata[CTRL_RUN_BIT] = q.run;
      end else if (S_AXI_ARADDR == ADDR_STATUS) begin
        n.rdata[ST_MODE_LSB+:2] = q.mode;
        n.rdata[ST_CAL_DONE]    = q.cal_done;
        n.rdata[ST_CHAN]        = q.chan;
        n.rdata[ST_RANGE]       = pins.bip;
        n.rdata[ST_PORT_FULL]   = q.port_full;
        n.rdata[ST_READY_N]     = q.rdy_n;
      end else if (S_AXI_ARADDR == ADDR_RESULT) begin
        n.rdata[19:0] = q.result;
      end else if (S_AXI_ARADDR == ADDR_OFFSET) begin
        n.rdata[19:0] = q.offset;
      end else begin
        n.rresp = RESP_SLVERR; // unmapped reads zero
      end
    end

    // one write and one read in flight at most
    n.awready = ~n.aw_got & ~n.bvalid;
    n.wready  = ~n.w_got & ~n.bvalid;
    n.arready = ~n.rvalid;
  end

  // single state register, synchronous reset
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      q <= ACC_STATE_RST;
    end else begin
      q <= n;
    end
  end

  // outputs straight from state flops
  assign SERIAL_OUT     = q.sdo;
  assign SERIAL_OUT_EN  = q.sdo_en;
  assign WORD_READY_N   = q.rdy_n;
  assign CHANNEL_ACTIVE = q.chan;
  assign S_AXI_AWREADY  = q.awready;
  assign S_AXI_WREADY   = q.wready;
  assign S_AXI_BVALID   = q.bvalid;
  assign S_AXI_BRESP    = q.bresp;
  assign S_AXI_ARREADY  = q.arready;
  assign S_AXI_RVALID   = q.rvalid;
  assign S_AXI_RDATA    = q.rdata;
  assign S_AXI_RRESP    = q.rresp;

endmodule : acc_sample_start_ctrl

// [verilog/acc_pkg.sv]
// shared constants, types and register map of the conversion control block
package acc_pkg;

  // timing, in master clock cycles
  localparam int          SAMPLE_START_CYCLES = 1624;            // filter settling per word
  localparam int          CAL_CYCLES  = 3248;            // self-calibration length
  localparam int          READY_LEAD  = 2;               // ready release ahead of update
  localparam int          CNT_W       = 13;              // wide enough for CAL_CYCLES
  localparam logic [12:0] SAMPLE_START_LOAD   = 13'(SAMPLE_START_CYCLES - 1);
  localparam logic [12:0] CAL_LOAD    = 13'(CAL_CYCLES - 1);
  localparam logic [12:0] LEAD_CNT    = 13'(READY_LEAD);

  // result word
  localparam int         WORD_BITS = 20;
  localparam logic [4:0] LAST_BIT  = 5'(WORD_BITS - 1);

  // axi4-lite register map, byte addresses
  localparam int         ADDR_W      = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_OFFSET = 8'h0c;

  // control fields
  localparam int   CTRL_RUN_BIT = 0;
  localparam logic CTRL_RUN_RST = 1'b1;

  // status fields
  localparam int ST_MODE_LSB  = 0;   // two bits
  localparam int ST_CAL_DONE  = 2;
  localparam int ST_CHAN      = 3;
  localparam int ST_RANGE     = 4;
  localparam int ST_PORT_FULL = 5;
  localparam int ST_READY_N   = 6;

  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // sequencer modes
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CAL  = 2'b01,
    ACC_SAMPLE_START = 2'b10
  } acc_mode_e;

  // control pins, grouped for one synchroniser
  typedef struct packed {
    logic sclk;    // serial shift clock
    logic sel_n;   // port select, active low
    logic chan;    // channel_select
    logic bip;     // signed_range_select
    logic trim;    // trim request
    logic start;   // sample_start
  } acc_pins_s;

  // whole state of the top module
  typedef struct packed {
    acc_mode_e         mode;
    logic [CNT_W-1:0]  cnt;
    logic              start_prev;
    logic              sclk_prev;
    logic              chan;
    logic              run;
    logic              cal_done;
    logic [19:0]       offset;
    logic [19:0]       result;
    logic [19:0]       shreg;
    logic [4:0]        bit_cnt;
    logic              port_full;
    logic              armed;
    logic              sdo;
    logic              sdo_en;
    logic              rdy_n;
    logic              aw_got;
    logic [ADDR_W-1:0] awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } acc_state_s;

  // mode named on its own; an enum field cannot take the plain zero default
  localparam acc_state_s ACC_STATE_RST = '{mode: ACC_IDLE, rdy_n: 1'b1, run: CTRL_RUN_RST,
                                           default: '0};

endpackage : acc_pkg

// [verilog/acc_sync2.sv]
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
module acc_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;   // first stage, read only by the second

  // both stages clear on reset so no unknown level reaches the sequencer
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : acc_sync2

// [dv/acc_host.sv]
// host model: drives port select and shift clock, reads one word
`timescale 1ns/1ps
module acc_host
  import acc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic sdo,
  input  wire logic sdo_en,
  output logic      sel_n,
  output logic      sclk
);
  // idle: deselected, clock parked low, never floating
  initial begin
    sel_n = 1'b1;
    sclk  = 1'b0;
  end
  // half = master cycles per clock level; must exceed the pin sync delay
  task automatic read_word(input int half, output logic [19:0] w, output bit ok);
    int i;
    w = '0;
    @(posedge sys_clk) sel_n <= 1'b0;
    for (i = 0; i < 40 && sdo_en !== 1'b1; i++) @(negedge sys_clk);
    ok = (sdo_en === 1'b1);
    // msb sampled before the arming rise, one fall per later bit
    for (i = WORD_BITS - 1; ok && i >= 0; i--) begin
      @(negedge sys_clk) w[i] = sdo;
      @(posedge sys_clk) sclk <= 1'b1;
      repeat (half) @(posedge sys_clk);
      sclk <= 1'b0;
      repeat (half) @(posedge sys_clk);
    end
    // stay selected until the port has emptied
    repeat (2 * half) @(posedge sys_clk);
    sel_n <= 1'b1;
  endtask : read_word
endmodule : acc_host

// [dv/acc_sample_start_ctrl_properties.sv]
// checker on the pins of the conversion control block
`timescale 1ns/1ps
module acc_sample_start_ctrl_chk (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic SAMPLE_START,
  input wire logic CHANNEL_SELECT,
  input wire logic PORT_SELECT_N,
  input wire logic SHIFT_CLK,
  input wire logic SERIAL_OUT,
  input wire logic SERIAL_OUT_EN,
  input wire logic WORD_READY_N,
  input wire logic CHANNEL_ACTIVE,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY
);
  logic [3:0]  fall_age_q; // cycles since shift clock fell
  logic [3:0]  rise_age_q; // cycles since start rose
  logic [11:0] gap_q;      // cycles since start rise or word load
  // saturating age counters; gap counter wraps
  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      fall_age_q <= 4'hf;
      rise_age_q <= 4'hf;
      gap_q      <= 12'h0;
    end else begin
      fall_age_q <= $fell(SHIFT_CLK) ? 4'h0 : fall_age_q + 4'(fall_age_q != 4'hf);
      rise_age_q <= $rose(SAMPLE_START) ? 4'h0 : rise_age_q + 4'(rise_age_q != 4'hf);
      gap_q <= ($rose(SAMPLE_START) || $fell(WORD_READY_N)) ? 12'h0 : gap_q + 12'h1;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_B);
  a_out_paced:
  assert property (SERIAL_OUT_EN && $past(SERIAL_OUT_EN) && $changed(SERIAL_OUT)
    |-> fall_age_q <= 4'h6) else $error("serial bit moved without a clock fall");
  a_chan_latch:
  assert property ($changed(CHANNEL_ACTIVE) |-> rise_age_q <= 4'h6
    && CHANNEL_ACTIVE == $past(CHANNEL_SELECT, 4)) else $error("channel moved off start");
  a_sample_start_time:
  assert property ($fell(WORD_READY_N) |-> gap_q inside {[12'd1620:12'd1632]})
    else $error("word load off conversion time");
  a_early_ready:
  assert property ($rose(WORD_READY_N) && PORT_SELECT_N |-> ##[1:3] !WORD_READY_N)
    else $error("deselected port not refilled");
  a_en_has_word:
  assert property ($rose(SERIAL_OUT_EN) |-> !WORD_READY_N && !$past(PORT_SELECT_N, 2))
    else $error("output enabled without word");
  a_lsb_empties:
  assert property ($fell(SERIAL_OUT_EN) && !PORT_SELECT_N |-> ##[0:1] WORD_READY_N)
    else $error("ready not released at end of word");
  a_b_once:
  assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("b twice");
  a_r_once:
  assert property (S_AXI_RVALID && S_AXI_RREADY |=> !S_AXI_RVALID) else $error("r twice");
  c_load: cover property ($fell(WORD_READY_N));
  c_refill: cover property ($rose(WORD_READY_N) && PORT_SELECT_N);
  c_read: cover property ($fell(SERIAL_OUT_EN) && !PORT_SELECT_N);
endmodule : acc_sample_start_ctrl_chk
bind acc_sample_start_ctrl acc_sample_start_ctrl_chk u_chk (
  .SYS_CLK        (SYS_CLK),        .RST_B          (RST_B),
  .SAMPLE_START   (SAMPLE_START),   .CHANNEL_SELECT (CHANNEL_SELECT),
  .PORT_SELECT_N  (PORT_SELECT_N),  .SHIFT_CLK      (SHIFT_CLK),
  .SERIAL_OUT     (SERIAL_OUT),     .SERIAL_OUT_EN  (SERIAL_OUT_EN),
  .WORD_READY_N   (WORD_READY_N),   .CHANNEL_ACTIVE (CHANNEL_ACTIVE),
  .S_AXI_BVALID   (S_AXI_BVALID),   .S_AXI_BREADY   (S_AXI_BREADY),
  .S_AXI_RVALID   (S_AXI_RVALID),   .S_AXI_RREADY   (S_AXI_RREADY)
);

// [dv/tb.sv]
// self-checking bench: registers, calibration, conversions, readout
`timescale 1ns/1ps
module tb;
  import acc_pkg::*;
  logic SYS_CLK, RST_B, SAMPLE_START, TRIM_REQUEST, SIGNED_RANGE_SELECT, CHANNEL_SELECT;
  logic PORT_SELECT_N, SHIFT_CLK, SERIAL_OUT, SERIAL_OUT_EN, WORD_READY_N, CHANNEL_ACTIVE;
  logic S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY, S_AXI_BVALID, S_AXI_BREADY;
  logic S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [3:0]  S_AXI_WSTRB;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, rsp;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, rd;
  logic [19:0] FILTER_WORD, off_q, fw_q, w;
  int          failures, cmp_count, seed, n, k;
  bit          ok;
  acc_sample_start_ctrl u_dut (
    .SYS_CLK             (SYS_CLK),             .RST_B          (RST_B),
    .SAMPLE_START        (SAMPLE_START),        .TRIM_REQUEST   (TRIM_REQUEST),
    .SIGNED_RANGE_SELECT (SIGNED_RANGE_SELECT), .CHANNEL_SELECT (CHANNEL_SELECT),
    .PORT_SELECT_N       (PORT_SELECT_N),       .SHIFT_CLK      (SHIFT_CLK),
    .FILTER_WORD         (FILTER_WORD),         .SERIAL_OUT     (SERIAL_OUT),
    .SERIAL_OUT_EN       (SERIAL_OUT_EN),       .WORD_READY_N   (WORD_READY_N),
    .CHANNEL_ACTIVE      (CHANNEL_ACTIVE),
    .S_AXI_AWVALID       (S_AXI_AWVALID),       .S_AXI_AWREADY  (S_AXI_AWREADY),
    .S_AXI_AWADDR        (S_AXI_AWADDR),        .S_AXI_WVALID   (S_AXI_WVALID),
    .S_AXI_WREADY        (S_AXI_WREADY),        .S_AXI_WDATA    (S_AXI_WDATA),
    .S_AXI_WSTRB         (S_AXI_WSTRB),         .S_AXI_BVALID   (S_AXI_BVALID),
    .S_AXI_BREADY        (S_AXI_BREADY),        .S_AXI_BRESP    (S_AXI_BRESP),
    .S_AXI_ARVALID       (S_AXI_ARVALID),       .S_AXI_ARREADY  (S_AXI_ARREADY),
    .S_AXI_ARADDR        (S_AXI_ARADDR),        .S_AXI_RVALID   (S_AXI_RVALID),
    .S_AXI_RREADY        (S_AXI_RREADY),        .S_AXI_RDATA    (S_AXI_RDATA),
    .S_AXI_RRESP         (S_AXI_RRESP)
  );
  acc_host u_host (.sys_clk(SYS_CLK), .sdo(SERIAL_OUT), .sdo_en(SERIAL_OUT_EN),
                   .sel_n(PORT_SELECT_N), .sclk(SHIFT_CLK));
  // 10 MHz master clock
  initial begin
    SYS_CLK = 1'b0;
    forever #50 SYS_CLK = ~SYS_CLK;
  end
  task automatic print_verdict();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one write; address and data offered together, each released when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    S_AXI_AWADDR  <= a;
    S_AXI_WDATA   <= d;
    S_AXI_WSTRB   <= 4'hf;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID  <= 1'b1;
    S_AXI_BREADY  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'b0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'b0;
      if (S_AXI_BVALID) break;
    end
    r = S_AXI_BRESP;
    S_AXI_BREADY <= 1'b0;
    if (i == 50) failures++;
    if (i == 50) print_verdict();
    @(posedge SYS_CLK);
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    S_AXI_ARADDR  <= a;
    S_AXI_ARVALID <= 1'b1;
    S_AXI_RREADY  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge SYS_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'b0;
      if (S_AXI_RVALID) break;
    end
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    if (i == 50) failures++;
    if (i == 50) print_verdict();
    @(posedge SYS_CLK);
  endtask : axi_rd
  // bounded wait for the ready pin to reach a level
  task automatic wait_rdy(input logic lvl, output int c);
    for (c = 0; c < 2000 && WORD_READY_N !== lvl; c++) @(posedge SYS_CLK);
    if (c == 2000) failures++;
    if (c == 2000) print_verdict();
  endtask : wait_rdy
  // expected port word from filter word, offset and range
  function automatic logic [19:0] exp_code(input logic [19:0] f, o, input logic bip);
    logic [19:0] d;
    d = f - o;
    if (bip) return {~d[19], d[18:0]};
    return d[19] ? 20'h0 : {d[18:0], 1'b0};
  endfunction : exp_code
  // read the port through the host and compare
  task automatic read_chk(input int half, input logic [19:0] exp);
    u_host.read_word(half, w, ok);
    chk(ok, 1'b1);
    chk(w, exp);
    @(posedge SYS_CLK);
  endtask : read_chk
  initial begin
    seed = 32'h5891dd70;
    {RST_B, SAMPLE_START, TRIM_REQUEST, SIGNED_RANGE_SELECT, CHANNEL_SELECT} = '0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, S_AXI_WSTRB} = '0;
    off_q = 20'($random(seed));
    FILTER_WORD = off_q;
    failures = 0;
    cmp_count = 0;
    repeat (12) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    // reset values, unmapped place, control write
    axi_rd(ADDR_CTRL, rd, rsp);
    chk(rd[0], CTRL_RUN_RST);
    axi_rd(ADDR_STATUS, rd, rsp);
    chk(rd[6:0], 7'h40);
    axi_rd(8'h10, rd, rsp);
    chk({rsp, rd}, {RESP_SLVERR, 32'h0});
    axi_wr(8'h10, 32'h0, rsp);
    chk(rsp, RESP_SLVERR);
    axi_wr(ADDR_CTRL, 32'h0, rsp);
    axi_rd(ADDR_CTRL, rd, rsp);
    chk(rd[0], 1'b0);
    axi_wr(ADDR_CTRL, 32'h1, rsp);
    chk(rsp, RESP_OKAY);
    // calibration on start rise with trim high
    TRIM_REQUEST <= 1'b1;
    SAMPLE_START <= 1'b1;
    repeat (CAL_CYCLES + 10) @(posedge SYS_CLK);
    SAMPLE_START <= 1'b0;
    TRIM_REQUEST <= 1'b0;
    // read-only place: write answered okay and ignored
    axi_wr(ADDR_OFFSET, {12'h0, ~off_q}, rsp);
    chk(rsp, RESP_OKAY);
    axi_rd(ADDR_OFFSET, rd, rsp);
    chk(rd[19:0], off_q);
    axi_rd(ADDR_STATUS, rd, rsp);
    chk({WORD_READY_N, rd[2:0]}, 4'hc);
    // single conversions, every channel and range, with corner words
    for (k = 0; k < 4; k++) begin
      CHANNEL_SELECT <= k[0];
      SIGNED_RANGE_SELECT <= k[1];
      fw_q = (k == 0) ? off_q - 20'h1 : (k == 3) ? off_q : 20'($random(seed));
      FILTER_WORD <= fw_q;
      repeat (8) @(posedge SYS_CLK);
      SAMPLE_START <= 1'b1;
      repeat (10) @(posedge SYS_CLK);
      SAMPLE_START <= 1'b0;
      CHANNEL_SELECT <= ~k[0];
      wait_rdy(1'b0, n);
      chk(n + 10 >= SAMPLE_START_CYCLES && n + 10 <= SAMPLE_START_CYCLES + 8, 1'b1);
      chk(CHANNEL_ACTIVE, k[0]);
      axi_rd(ADDR_STATUS, rd, rsp);
      chk(rd[6:0], {2'b01, k[1], k[0], 3'b100});
      read_chk(6 + 4 * k, exp_code(fw_q, off_q, k[1]));
      axi_rd(ADDR_RESULT, rd, rsp);
      chk({WORD_READY_N, rd[19:0]}, {1'b1, exp_code(fw_q, off_q, k[1])});
    end
    // continuous run; word replaced while deselected, then two reads
    SAMPLE_START <= 1'b1;
    wait_rdy(1'b0, n);
    fw_q = 20'($random(seed));
    FILTER_WORD <= fw_q;
    wait_rdy(1'b1, n);
    wait_rdy(1'b0, n);
    chk(n < 4, 1'b1);
    FILTER_WORD <= off_q + 20'h5;
    read_chk(6, exp_code(fw_q, off_q, 1'b1));
    wait_rdy(1'b0, n);
    read_chk(7, exp_code(off_q + 20'h5, off_q, 1'b1));
    SAMPLE_START <= 1'b0;
    print_verdict();
  end
endmodule : tb
